// file: hw/exec_tail.sv
// Execution unit for rotate, subtract, skip, set, swap, table read, XOR.
// Assumes a sequencer that presents one instruction when start pulses
// and holds the request stable until done.
`timescale 1ns/10ps
`include "exec_tail_cfg.svh"
module exec_tail
  import exec_tail_pkg::*;
#(
  parameter int PC_W  = `PC_W,
  parameter int PTR_W = `TBL_PTR_W
) (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    nrst,
  // Instruction request
  input  wire logic                    start,
  input  wire exec_tail_pkg::exec_req_t req,
  input  wire logic [PC_W-1:0]         pc,
  input  wire logic [PTR_W-1:0]        table_pointer,
  // Program memory
  output logic      [PC_W-1:0]         prog_addr,
  input  wire logic [`PROG_W-1:0]      prog_word,
  // Results
  output exec_tail_pkg::mem_res_t      mem_res,
  output logic      [`DATA_W-1:0]      working_register,
  output exec_tail_pkg::flags_t        flags,
  output logic      [5:0]              table_high_byte,
  output logic                         busy,
  output logic                         done
);
  import exec_tail_pkg::*;

  logic [7:0] m;
  logic [7:0] sub_rhs;
  logic       sub_bin;
  logic [7:0] diff;
  logic       s_ov;
  logic       s_ac;
  logic       s_c;
  logic [PC_W-1:0] addr_c;
  logic [7:0] tbl_low;
  logic [5:0] tbl_high;
  logic [7:0] onehot;

  mem_res_t   mem_res_reg;
  mem_res_t   mem_res_next;
  logic [7:0] acc_reg;
  logic [7:0] acc_next;
  flags_t     flags_reg;
  flags_t     flags_next;
  logic [5:0] table_high_byte_reg;
  logic [5:0] table_high_byte_next;
  logic [PC_W-1:0] paddr_reg;
  logic [PC_W-1:0] paddr_next;
  logic [1:0] cyc_reg;
  logic [1:0] cyc_next;
  logic       done_reg;
  logic       done_next;

  assign m = req.mem_data;

  // Bit select decoder, one bit per lane.
  for (genvar i = 0; i < 8; i++) begin : g_sel
    assign onehot[i] = (req.bit_sel == 3'(i));
  end

  subtract_unit u_sub (
    .minuend    (acc_reg),
    .subtrahend (sub_rhs),
    .borrow_in  (sub_bin),
    .diff       (diff),
    .ov         (s_ov),
    .ac         (s_ac),
    .c          (s_c)
  );

  table_fetch #(.PC_W(PC_W), .PTR_W(PTR_W)) u_tbl (
    .last_page     (req.op == table_read_last_page),
    .pc            (pc),
    .table_pointer (table_pointer),
    .prog_addr     (addr_c),
    .prog_word     (prog_word),
    .low_byte      (tbl_low),
    .high_part     (tbl_high)
  );

  always_comb begin
    sub_rhs = (req.op == subtract_immediate) ? req.imm_data : m;
    sub_bin = ((req.op == subtract_with_borrow) ||
               (req.op == subtract_with_borrow_to_mem)) ? ~flags_reg.c
              : 1'b0;
  end

  always_comb begin
    mem_res_next = '0;
    acc_next     = acc_reg;
    flags_next   = flags_reg;
    table_high_byte_next    = table_high_byte_reg;
    paddr_next   = paddr_reg;
    cyc_next     = (cyc_reg != 2'h0) ? cyc_reg - 2'h1 : 2'h0;
    done_next    = (cyc_reg == 2'h2);
    if (start && (cyc_reg == 2'h0)) begin
      cyc_next  = `PLAIN_CYCLES;
      done_next = 1'b1;
      case (req.op)
        rotate_left_to_work: begin
          acc_next = {m[6:0], m[7]};
        end
        rotate_left_thru_carry: begin
          mem_res_next.mem_we    = 1'b1;
          mem_res_next.mem_wdata = {m[6:0], flags_reg.c};
          flags_next.c           = m[7];
        end
        rotate_left_thru_carry_to_work: begin
          acc_next     = {m[6:0], flags_reg.c};
          flags_next.c = m[7];
        end
        rotate_right: begin
          mem_res_next.mem_we    = 1'b1;
          mem_res_next.mem_wdata = {m[0], m[7:1]};
        end
        rotate_right_to_work: begin
          acc_next = {m[0], m[7:1]};
        end
        rotate_right_thru_carry: begin
          mem_res_next.mem_we    = 1'b1;
          mem_res_next.mem_wdata = {flags_reg.c, m[7:1]};
          flags_next.c           = m[0];
        end
        rotate_right_thru_carry_to_work: begin
          acc_next     = {flags_reg.c, m[7:1]};
          flags_next.c = m[0];
        end
        subtract_with_borrow, subtract_plain, subtract_immediate,
        subtract_with_borrow_to_mem, subtract_to_mem: begin
          if ((req.op == subtract_with_borrow_to_mem) ||
              (req.op == subtract_to_mem)) begin
            mem_res_next.mem_we    = 1'b1;
            mem_res_next.mem_wdata = diff;
          end else begin
            acc_next = diff;
          end
          flags_next.ov = s_ov;
          flags_next.ac = s_ac;
          flags_next.c  = s_c;
          flags_next.z  = (diff == `BYTE_ZERO);
        end
        decrement_skip_zero: begin
          mem_res_next.mem_we    = 1'b1;
          mem_res_next.mem_wdata = m - 8'h01;
          mem_res_next.skip      = (m == 8'h01);
        end
        decrement_skip_zero_to_work: begin
          acc_next          = m - 8'h01;
          mem_res_next.skip = (m == 8'h01);
        end
        increment_skip_zero: begin
          mem_res_next.mem_we    = 1'b1;
          mem_res_next.mem_wdata = m + 8'h01;
          mem_res_next.skip      = (m == `BYTE_ALL_ONES);
        end
        increment_skip_zero_to_work: begin
          acc_next          = m + 8'h01;
          mem_res_next.skip = (m == `BYTE_ALL_ONES);
        end
        set_byte: begin
          mem_res_next.mem_we    = 1'b1;
          mem_res_next.mem_wdata = `BYTE_ALL_ONES;
        end
        set_bit: begin
          mem_res_next.mem_we    = 1'b1;
          mem_res_next.mem_wdata = m | onehot;
        end
        skip_if_bit_set: begin
          mem_res_next.skip = |(m & onehot);
        end
        skip_if_bit_clear: begin
          mem_res_next.skip = ~|(m & onehot);
        end
        skip_if_zero: begin
          mem_res_next.skip = (m == `BYTE_ZERO);
        end
        move_and_skip_zero: begin
          acc_next          = m;
          mem_res_next.skip = (m == `BYTE_ZERO);
        end
        nibble_exchange: begin
          mem_res_next.mem_we    = 1'b1;
          mem_res_next.mem_wdata = {m[3:0], m[7:4]};
        end
        nibble_exchange_to_work: begin
          acc_next = {m[3:0], m[7:4]};
        end
        table_read_current_page, table_read_last_page: begin
          paddr_next             = addr_c;
          mem_res_next.mem_we    = 1'b1;
          mem_res_next.mem_wdata = tbl_low;
          table_high_byte_next              = tbl_high;
        end
        exclusive_or, exclusive_or_immediate: begin
          acc_next = acc_reg ^ ((req.op == exclusive_or_immediate)
                     ? req.imm_data : m);
          flags_next.z = (acc_next == `BYTE_ZERO);
        end
        exclusive_or_to_mem: begin
          mem_res_next.mem_we    = 1'b1;
          mem_res_next.mem_wdata = acc_reg ^ m;
          flags_next.z = ((acc_reg ^ m) == `BYTE_ZERO);
        end
        default: acc_next = acc_reg;
      endcase
      // A taken skip holds the unit one more cycle for the dummy slot.
      if (mem_res_next.skip) begin
        cyc_next  = `SKIP_CYCLES;
        done_next = 1'b0;
      end
    end else begin
      mem_res_next.skip = mem_res_reg.skip & (cyc_reg == 2'h2);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      mem_res_reg <= '0;
      acc_reg     <= 8'h00;
      flags_reg   <= '0;
      table_high_byte_reg    <= 6'h00;
      paddr_reg   <= '0;
      cyc_reg     <= 2'h0;
      done_reg    <= 1'b0;
    end else begin
      mem_res_reg <= mem_res_next;
      acc_reg     <= acc_next;
      flags_reg   <= flags_next;
      table_high_byte_reg    <= table_high_byte_next;
      paddr_reg   <= paddr_next;
      cyc_reg     <= cyc_next;
      done_reg    <= done_next;
    end
  end

  always_comb begin
    mem_res          = mem_res_reg;
    working_register = acc_reg;
    flags            = flags_reg;
    table_high_byte  = table_high_byte_reg;
    prog_addr        = paddr_reg;
    busy             = (cyc_reg != 2'h0);
    done             = done_reg;
  end

  property p_skip_two_cycles;
    @(posedge clk) disable iff (!nrst)
      (start && !busy && (req.op == skip_if_zero) &&
       (req.mem_data == 8'h00)) |=> busy ##1 done;
  endproperty
  a_skip_two_cycles: assert property (p_skip_two_cycles)
    else $error("Skip did not take two cycles.");

  property p_set_byte;
    @(posedge clk) disable iff (!nrst)
      (start && !busy && (req.op == set_byte)) |=>
        mem_res.mem_we && (mem_res.mem_wdata == 8'hFF);
  endproperty
  a_set_byte: assert property (p_set_byte)
    else $error("Set byte did not write all ones.");

  property p_rot_left_c;
    @(posedge clk) disable iff (!nrst)
      (start && !busy && (req.op == rotate_left_thru_carry)) |=>
        (mem_res.mem_wdata == {$past(req.mem_data[6:0]),
                               $past(flags.c)}) &&
        (flags.c == $past(req.mem_data[7]));
  endproperty
  a_rot_left_c: assert property (p_rot_left_c)
    else $error("Rotate left through carry wrong.");

  property p_sub_carry;
    @(posedge clk) disable iff (!nrst)
      (start && !busy && (req.op == subtract_plain)) |=>
        flags.c == ($past(working_register) >= $past(req.mem_data));
  endproperty
  a_sub_carry: assert property (p_sub_carry)
    else $error("Subtract carry flag wrong.");

  property p_rot_right_work;
    @(posedge clk) disable iff (!nrst)
      (start && !busy && (req.op == rotate_right_to_work)) |=>
        !mem_res.mem_we && $stable(flags) &&
        (working_register == {$past(req.mem_data[0]),
                              $past(req.mem_data[7:1])});
  endproperty
  a_rot_right_work: assert property (p_rot_right_work)
    else $error("Rotate right to work wrong.");

  property p_inc_skip;
    @(posedge clk) disable iff (!nrst)
      (start && !busy && (req.op == increment_skip_zero)) |=>
        (mem_res.skip == (mem_res.mem_wdata == 8'h00)) && $stable(flags);
  endproperty
  a_inc_skip: assert property (p_inc_skip)
    else $error("Increment skip wrong.");

  property p_xor_zero;
    @(posedge clk) disable iff (!nrst)
      (start && !busy && (req.op == exclusive_or)) |=>
        flags.z == (working_register == 8'h00);
  endproperty
  a_xor_zero: assert property (p_xor_zero)
    else $error("Zero flag wrong after XOR.");

  property p_swap_mem;
    @(posedge clk) disable iff (!nrst)
      (start && !busy && (req.op == nibble_exchange)) |=>
        mem_res.mem_wdata == {$past(req.mem_data[3:0]),
                              $past(req.mem_data[7:4])};
  endproperty
  a_swap_mem: assert property (p_swap_mem)
    else $error("Nibble swap wrong.");
endmodule : exec_tail

// file: hw/exec_tail_cfg.svh
// Constants for the instruction execution tail: widths, byte values,
// cycle counts. Assumes inclusion by the package and exec_tail.
`ifndef EXEC_TAIL_CFG_SVH
`define EXEC_TAIL_CFG_SVH
`define DATA_W        8
`define PROG_W        14
`define PC_W          12
`define TBL_PTR_W     8
`define BYTE_ALL_ONES 8'hFF
`define BYTE_ZERO     8'h00
`define SKIP_CYCLES   2'h2
`define PLAIN_CYCLES  2'h1
`define LAST_PAGE     4'hF
`endif

// file: hw/exec_tail_pkg.sv
// Types for the instruction execution tail.
// Assumes exec_tail_cfg.svh is on the include path.
`include "exec_tail_cfg.svh"
package exec_tail_pkg;
  typedef enum logic [4:0] {
    op_none,
    rotate_left_to_work,
    rotate_left_thru_carry,
    rotate_left_thru_carry_to_work,
    rotate_right,
    rotate_right_to_work,
    rotate_right_thru_carry,
    rotate_right_thru_carry_to_work,
    subtract_with_borrow,
    subtract_with_borrow_to_mem,
    subtract_plain,
    subtract_to_mem,
    subtract_immediate,
    decrement_skip_zero,
    decrement_skip_zero_to_work,
    increment_skip_zero,
    increment_skip_zero_to_work,
    set_byte,
    set_bit,
    skip_if_bit_set,
    skip_if_bit_clear,
    skip_if_zero,
    move_and_skip_zero,
    nibble_exchange,
    nibble_exchange_to_work,
    table_read_current_page,
    table_read_last_page,
    exclusive_or,
    exclusive_or_to_mem,
    exclusive_or_immediate
  } opcode_t;

  typedef struct packed {
    opcode_t                    op;
    logic [`DATA_W-1:0]         mem_data;
    logic [`DATA_W-1:0]         imm_data;
    logic [2:0]                 bit_sel;
  } exec_req_t;

  typedef struct packed {
    logic                       ov;
    logic                       z;
    logic                       ac;
    logic                       c;
  } flags_t;

  typedef struct packed {
    logic                       mem_we;
    logic [`DATA_W-1:0]         mem_wdata;
    logic                       skip;
  } mem_res_t;
endpackage : exec_tail_pkg

// file: hw/subtract_unit.sv
// Eight-bit subtractor with borrow, producing the ov, ac and c flags; z is formed by the caller.
// Purely combinational; assumes the caller registers its results.
`timescale 1ns/10ps
module subtract_unit (
  // Operands
  input  wire logic [7:0]  minuend,
  input  wire logic [7:0]  subtrahend,
  input  wire logic        borrow_in,
  // Result
  output logic      [7:0]  diff,
  output logic             ov,
  output logic             ac,
  output logic             c
);
  logic [8:0] full;
  logic [4:0] low;
  always_comb begin
    full = {1'b0, minuend} - {1'b0, subtrahend} - {8'h00, borrow_in};
    low  = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]}
         - {4'h0, borrow_in};
    diff = full[7:0];
    // Carry means no borrow, so it is the inverse of the borrow out.
    c    = ~full[8];
    ac   = ~low[4];
    ov   = (minuend[7] ^ subtrahend[7]) & (minuend[7] ^ full[7]);
  end
endmodule : subtract_unit

// file: hw/table_fetch.sv
// Table read address former and result splitter for program memory.
// Assumes program memory answers combinationally to the address.
`timescale 1ns/10ps
module table_fetch #(
  parameter int PC_W  = 12,
  parameter int PTR_W = 8
) (
  // Request
  input  wire logic             last_page,
  input  wire logic [PC_W-1:0]  pc,
  input  wire logic [PTR_W-1:0] table_pointer,
  // Program memory
  output logic      [PC_W-1:0]  prog_addr,
  input  wire logic [13:0]      prog_word,
  // Result
  output logic      [7:0]       low_byte,
  output logic      [5:0]       high_part
);
  always_comb begin
    // Page bits come from the program counter or are all ones.
    if (last_page) begin
      prog_addr = {{(PC_W-PTR_W){1'b1}}, table_pointer};
    end else begin
      prog_addr = {pc[PC_W-1:PTR_W], table_pointer};
    end
    low_byte  = prog_word[7:0];
    high_part = prog_word[13:8];
  end
endmodule : table_fetch

// file: testbench/exec_tail_bench.sv
// Self-checking bench for the instruction execution tail.
// Assumes the design package, its header and exec_tail are compiled first.
`timescale 1ns/10ps
module exec_tail_bench;
  import exec_tail_pkg::*;
  typedef struct {
    logic [7:0]  work;
    flags_t      fl;
    logic        we;
    logic [7:0]  wd;
    logic        sk;
    logic [5:0]  th;
    logic [11:0] pa;
    int          lat;
    int          t0;
  } note_t;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        start = 1'b0;
  exec_req_t   req = '0;
  logic [11:0] pc = 12'h000;
  logic [7:0]  table_pointer = 8'h00;
  logic [13:0] prog_word;
  logic [11:0] prog_addr;
  mem_res_t    mem_res;
  logic [7:0]  working_register;
  flags_t      flags;
  logic [5:0]  table_high_byte;
  logic        busy;
  logic        done;
  int          bad_count = 0;
  int          checks = 0;
  int          cyc = 0;
  int          we_cnt = 0;
  logic [7:0]  wd_seen = 8'h00;
  note_t       notes[$];
  // Reference state; a reset clears it like the design's registers.
  logic [7:0]  work_m = 8'h00;
  flags_t      fl_m = '0;
  logic [5:0]  th_m = 6'h00;
  logic [11:0] pa_m = 12'h000;

  exec_tail i_dut (
    .clk(clk), .nrst(nrst), .start(start), .req(req), .pc(pc),
    .table_pointer(table_pointer), .prog_addr(prog_addr),
    .prog_word(prog_word), .mem_res(mem_res),
    .working_register(working_register), .flags(flags),
    .table_high_byte(table_high_byte), .busy(busy), .done(done)
  );

  always #4 clk = ~clk;

  function automatic logic [11:0] taddr(input opcode_t op,
                                        input logic [11:0] p,
                                        input logic [7:0] t);
    return (op == table_read_last_page) ? {4'hF, t} : {p[11:8], t};
  endfunction : taddr

  // Every address bit reaches the word, so a wrong page shows up.
  function automatic logic [13:0] rom(input logic [11:0] a);
    return {a[5:0] ^ a[11:6], a[7:0] + 8'h5A};
  endfunction : rom

  assign prog_word = rom(taddr(req.op, pc, table_pointer));

  function automatic logic [7:0] pick();
    case ($urandom_range(5, 0))
      0: return 8'h00;
      1: return 8'h01;
      2: return 8'hFF;
      3: return 8'h80;
      4: return 8'h7F;
      default: return 8'($urandom);
    endcase
  endfunction : pick

  task automatic check(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      close_out();
    end
  end

  task automatic predict(input exec_req_t r, output note_t n);
    logic [7:0]  m;
    logic [7:0]  s;
    logic [7:0]  res;
    logic [8:0]  d;
    logic [4:0]  h;
    logic        sub;
    logic        bin;
    logic [11:0] a;
    logic [13:0] w;
    m = r.mem_data;
    s = m;
    res = 8'h00;
    sub = 1'b0;
    bin = 1'b0;
    n.sk = 1'b0;
    case (r.op)
      rotate_left_to_work: res = {m[6:0], m[7]};
      rotate_left_thru_carry, rotate_left_thru_carry_to_work: begin
        res = {m[6:0], fl_m.c};
        fl_m.c = m[7];
      end
      rotate_right, rotate_right_to_work: res = {m[0], m[7:1]};
      rotate_right_thru_carry, rotate_right_thru_carry_to_work: begin
        res = {fl_m.c, m[7:1]};
        fl_m.c = m[0];
      end
      subtract_with_borrow, subtract_with_borrow_to_mem: begin
        bin = ~fl_m.c;
        sub = 1'b1;
      end
      subtract_plain, subtract_to_mem: sub = 1'b1;
      subtract_immediate: begin
        s = r.imm_data;
        sub = 1'b1;
      end
      decrement_skip_zero, decrement_skip_zero_to_work: begin
        res = m - 8'h01;
        n.sk = (res == 8'h00);
      end
      increment_skip_zero, increment_skip_zero_to_work: begin
        res = m + 8'h01;
        n.sk = (res == 8'h00);
      end
      set_byte: res = 8'hFF;
      set_bit: res = m | (8'h01 << r.bit_sel);
      skip_if_bit_set: n.sk = m[r.bit_sel];
      skip_if_bit_clear: n.sk = ~m[r.bit_sel];
      skip_if_zero: n.sk = (m == 8'h00);
      move_and_skip_zero: begin
        res = m;
        n.sk = (m == 8'h00);
      end
      nibble_exchange, nibble_exchange_to_work: res = {m[3:0], m[7:4]};
      table_read_current_page, table_read_last_page: begin
        a = taddr(r.op, pc, table_pointer);
        w = rom(a);
        res = w[7:0];
        th_m = w[13:8];
        pa_m = a;
      end
      exclusive_or, exclusive_or_to_mem: res = work_m ^ m;
      exclusive_or_immediate: res = work_m ^ r.imm_data;
      default: res = 8'h00;
    endcase
    if (sub) begin
      d = {1'b0, work_m} - {1'b0, s} - {8'h00, bin};
      h = {1'b0, work_m[3:0]} - {1'b0, s[3:0]} - {4'h0, bin};
      res = d[7:0];
      fl_m.ov = (work_m[7] != s[7]) && (d[7] != work_m[7]);
      fl_m.c = ~d[8];
      fl_m.ac = ~h[4];
    end
    if (sub || r.op inside {exclusive_or, exclusive_or_to_mem,
                            exclusive_or_immediate}) begin
      fl_m.z = (res == 8'h00);
    end
    n.we = r.op inside {rotate_left_thru_carry, rotate_right,
      rotate_right_thru_carry, subtract_with_borrow_to_mem, subtract_to_mem,
      decrement_skip_zero, increment_skip_zero, set_byte, set_bit,
      nibble_exchange, table_read_current_page, table_read_last_page,
      exclusive_or_to_mem};
    n.wd = res;
    if (r.op inside {rotate_left_to_work, rotate_left_thru_carry_to_work,
      rotate_right_to_work, rotate_right_thru_carry_to_work,
      subtract_with_borrow, subtract_plain, subtract_immediate,
      decrement_skip_zero_to_work, increment_skip_zero_to_work,
      move_and_skip_zero, nibble_exchange_to_work, exclusive_or,
      exclusive_or_immediate}) begin
      work_m = res;
    end
    n.work = work_m;
    n.fl = fl_m;
    n.th = th_m;
    n.pa = pa_m;
    n.lat = n.sk ? 2 : 1;
  endtask : predict

  // A ghost keeps start high into a busy cycle; it must not be taken.
  task automatic issue(input opcode_t op, input logic ghost);
    exec_req_t r;
    note_t     n;
    r.op = op;
    r.mem_data = pick();
    r.imm_data = pick();
    r.bit_sel = 3'($urandom);
    pc = 12'($urandom);
    table_pointer = 8'($urandom);
    predict(r, n);
    n.t0 = cyc;
    notes.push_back(n);
    req = r;
    start = 1'b1;
    @(posedge clk);
    #1;
    if (ghost) begin
      @(posedge clk);
      #1;
    end
    start = 1'b0;
    for (int w = 0; w < 8 && busy === 1'b1; w++) begin
      @(posedge clk);
      #1;
    end
  endtask : issue

  task automatic do_reset();
    nrst = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    nrst = 1'b1;
    work_m = 8'h00;
    fl_m = '0;
    th_m = 6'h00;
    pa_m = 12'h000;
    check(working_register === 8'h00 && flags === 4'h0 &&
          table_high_byte === 6'h00 && prog_addr === 12'h000 &&
          mem_res === '0 && busy === 1'b0 && done === 1'b0,
          "values after reset");
  endtask : do_reset

  always @(negedge clk) begin
    note_t n;
    if (nrst !== 1'b1) begin
      we_cnt = 0;
    end else begin
      if (mem_res.mem_we === 1'b1) begin
        we_cnt++;
        wd_seen = mem_res.mem_wdata;
      end
      if (done === 1'b1 && notes.size() == 0) begin
        check(1'b0, "done with nothing pending");
      end else if (done === 1'b1) begin
        n = notes.pop_front();
        check(working_register === n.work, "work register");
        check(flags === n.fl, "flags");
        check(table_high_byte === n.th, "table high byte");
        check(prog_addr === n.pa, "table address");
        check(we_cnt == (n.we ? 1 : 0), "write strobe count");
        check(n.we ? wd_seen === n.wd : 1'b1, "write data");
        check(mem_res.skip === n.sk, "skip");
        check(cyc - n.t0 == n.lat, "done latency");
        we_cnt = 0;
      end
    end
  end

  initial begin
    opcode_t op;
    void'($urandom(12649));
    do_reset();
    for (int k = 0; k < 30; k++) begin
      repeat (12) issue(opcode_t'(k), 1'b0);
    end
    do_reset();
    repeat (400) begin
      op = opcode_t'($urandom_range(29, 0));
      issue(op, $urandom_range(7, 0) == 0);
    end
    repeat (4) @(posedge clk);
    close_out();
  end
endmodule : exec_tail_bench
